// ---- logic/psb_pkg.sv ----
// Operation
// - strap low linear, high or open interleaved
// - synchronous inputs registered on rising edge, except read hold, which acts unregistered
// - read data leaves through output register
// - either address strobe starts an access
// - two-bit counter loads first address low bits
// - counter steps only when advance low
// - lane written when qualifier and lane select low
// - global write writes every lane
// - read needs strobe, selects; with controller strobe also write controls high
// - start address loaded into register and counter
// - read data driven after next edge if enabled
// - first cycle from deselect stays high impedance
// - back-to-back single reads without idle cycles
// - deselect turns data drivers off at once
// - processor-strobe write ignores controls first cycle
// - processor-strobe write decided at second edge
// - unselected lanes keep their stored contents
// - write cycle forces data drivers off
// - both strobes active, processor strobe wins
// - interleaved order is start xor step count
// - linear order counts up, wraps modulo four
package psb_pkg;
  localparam int PSB_ADDR_W = 18;
  localparam int PSB_DATA_W = 36;
  localparam int PSB_LANES = 4;
  localparam int PSB_BUF_DEPTH = 2;
  localparam logic PSB_LOW_ACT_RST = 1'b1;
  localparam logic PSB_HIGH_ACT_RST = 1'b0;
  localparam logic PSB_MODE_RST = 1'b1;
  localparam logic [1:0] PSB_LOW_RST = 2'h0;
  localparam logic [1:0] PSB_STEP_ONE = 2'h1;

  typedef enum logic [2:0] {
    PSB_IDLE = 3'h1,
    PSB_WAIT_WR = 3'h2,
    PSB_BURST = 3'h4
  } psb_state_t;

  // burst address low bits for a given step from the first address
  function automatic logic [1:0] psb_burst_low(input logic [1:0] first,
      input logic [1:0] step, input logic interleaved);
    return interleaved ? (first ^ step) : 2'(first + step);
  endfunction
endpackage

// ---- logic/psb_buf_if.sv ----
`timescale 1ns/1ns
interface psb_buf_if import psb_pkg::*; #(parameter int W = PSB_DATA_W) ();
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fill (output in_valid, output in_data, output out_ready,
    input in_ready, input out_valid, input out_data);
  modport buf_side (input in_valid, input in_data, input out_ready,
    output in_ready, output out_valid, output out_data);
endinterface

// ---- logic/psb_rd_buf.sv ----
`timescale 1ns/1ns
module psb_rd_buf import psb_pkg::*; #(
  parameter int DEPTH = PSB_BUF_DEPTH,
  parameter int W = PSB_DATA_W
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  psb_buf_if.buf_side bus
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [W-1:0] slot_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic push;
  logic pop;

  // slots are the output register of the read path
  assign bus.in_ready = (count_r != FULL);
  assign bus.out_valid = (count_r != '0);
  assign bus.out_data = slot_r[rd_ptr_r];
  assign push = bus.in_valid && bus.in_ready;
  assign pop = bus.out_valid && bus.out_ready;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        slot_r[i] <= '0;
      end
    end else if (push) begin
      slot_r[wr_ptr_r] <= bus.in_data;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : PW'(wr_ptr_r + 1'b1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : PW'(rd_ptr_r + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_r <= '0;
    end else if (push && !pop) begin
      count_r <= (PW+1)'(count_r + 1'b1);
    end else if (pop && !push) begin
      count_r <= (PW+1)'(count_r - 1'b1);
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  AST_BUF_STALL_HOLD:
  assert property (bus.out_valid && !bus.out_ready |=>
      bus.out_valid && $stable(bus.out_data))
    else $error("stalled buffer head lost");
endmodule

// ---- logic/psb_sram_core.sv ----
`timescale 1ns/1ns
module psb_sram_core import psb_pkg::*; #(
  parameter int ADDR_W = PSB_ADDR_W,
  parameter int DATA_W = PSB_DATA_W,
  parameter int LANES = PSB_LANES
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic burst_step_n_in,
  input wire logic all_lanes_write_n_in,
  input wire logic lane_write_qualifier_n_in,
  input wire logic [LANES-1:0] lane_write_select_n_in,
  input wire logic select_primary_n_in,
  input wire logic select_high_in,
  input wire logic select_third_n_in,
  input wire logic out_enable_n_in,
  input wire logic burst_mode_in,
  input wire logic read_hold_in,
  output logic read_ready_out
);
  localparam int LANE_W = DATA_W / LANES;
  localparam int WORDS = 1 << ADDR_W;

  // input registers
  logic proc_addr_strobe_n_r;
  logic ctrl_addr_strobe_n_r;
  logic burst_step_n_r;
  logic all_lanes_write_n_r;
  logic lane_write_qualifier_n_r;
  logic [LANES-1:0] lane_write_select_n_r;
  logic select_primary_n_r;
  logic select_high_r;
  logic select_third_n_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] din_r;
  logic mode_r;

  // burst and access state
  psb_state_t state_r;
  psb_state_t state_nxt;
  logic [1:0] first_r;
  logic [1:0] step_r;
  logic [1:0] step_nxt;
  logic [ADDR_W-3:0] base_r;
  logic mask_r;

  logic [DATA_W-1:0] mem [WORDS];

  logic sel_all;
  logic p_start;
  logic c_start;
  logic start;
  logic cont;
  logic write_ctl;
  logic acc_wr;
  logic acc_rd;
  logic deselect;
  logic [LANES-1:0] lane_we;
  logic [1:0] cur_low;
  logic [ADDR_W-1:0] cur_addr;
  logic [DATA_W-1:0] rd_data;
  logic [LANE_W-1:0] din_lane0;

  psb_buf_if #(.W(DATA_W)) bif ();

  psb_rd_buf #(.DEPTH(PSB_BUF_DEPTH), .W(DATA_W)) u_rd_buf (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .bus(bif.buf_side)
  );

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      proc_addr_strobe_n_r <= PSB_LOW_ACT_RST;
      ctrl_addr_strobe_n_r <= PSB_LOW_ACT_RST;
      burst_step_n_r <= PSB_LOW_ACT_RST;
      all_lanes_write_n_r <= PSB_LOW_ACT_RST;
      lane_write_qualifier_n_r <= PSB_LOW_ACT_RST;
      lane_write_select_n_r <= '1;
      select_primary_n_r <= PSB_LOW_ACT_RST;
      select_high_r <= PSB_HIGH_ACT_RST;
      select_third_n_r <= PSB_LOW_ACT_RST;
      addr_r <= '0;
      din_r <= '0;
    end else begin
      proc_addr_strobe_n_r <= proc_addr_strobe_n_in;
      ctrl_addr_strobe_n_r <= ctrl_addr_strobe_n_in;
      burst_step_n_r <= burst_step_n_in;
      all_lanes_write_n_r <= all_lanes_write_n_in;
      lane_write_qualifier_n_r <= lane_write_qualifier_n_in;
      lane_write_select_n_r <= lane_write_select_n_in;
      select_primary_n_r <= select_primary_n_in;
      select_high_r <= select_high_in;
      select_third_n_r <= select_third_n_in;
      addr_r <= addr_in;
      din_r <= dq_in;
    end
  end

  // strap is expected static, so plain sampling is enough
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_r <= PSB_MODE_RST;
    end else begin
      mode_r <= burst_mode_in;
    end
  end

  assign sel_all = ~select_primary_n_r & select_high_r &
    ~select_third_n_r;
  // processor strobe ignored while the primary select is high
  assign p_start = ~proc_addr_strobe_n_r & ~select_primary_n_r;
  assign c_start = ~ctrl_addr_strobe_n_r & ~p_start;
  assign start = p_start | c_start;
  assign deselect = start & ~sel_all;
  assign cont = ~start & (state_r != PSB_IDLE);
  assign write_ctl = ~all_lanes_write_n_r | ~lane_write_qualifier_n_r;

  // processor-strobe start never writes in its first cycle
  assign acc_wr = (c_start & sel_all & write_ctl) |
    (cont & write_ctl);
  assign acc_rd = (start & sel_all & ~acc_wr) |
    (cont & ~write_ctl);

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign lane_we[g] = ~all_lanes_write_n_r |
        (~lane_write_qualifier_n_r & ~lane_write_select_n_r[g]);
    end
  endgenerate

  assign step_nxt = burst_step_n_r ? step_r :
    2'(step_r + PSB_STEP_ONE);
  assign cur_low = start ? addr_r[1:0] :
    psb_burst_low(first_r, step_nxt, mode_r);
  assign cur_addr = start ? addr_r : {base_r, cur_low};
  assign rd_data = mem[cur_addr];
  assign din_lane0 = din_r[LANE_W-1:0];

  always_comb begin
    state_nxt = state_r;
    if (start) begin
      if (!sel_all) begin
        state_nxt = PSB_IDLE;
      end else if (p_start) begin
        state_nxt = PSB_WAIT_WR;
      end else begin
        state_nxt = PSB_BURST;
      end
    end else begin
      unique case (state_r)
        PSB_IDLE: state_nxt = PSB_IDLE;
        PSB_WAIT_WR: state_nxt = PSB_BURST;
        PSB_BURST: state_nxt = PSB_BURST;
        default: state_nxt = PSB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= PSB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      first_r <= PSB_LOW_RST;
      step_r <= PSB_LOW_RST;
      base_r <= '0;
    end else if (start && sel_all) begin
      first_r <= addr_r[1:0];
      step_r <= PSB_LOW_RST;
      base_r <= addr_r[ADDR_W-1:2];
    end else if (cont) begin
      step_r <= step_nxt;
    end
  end

  // first data cycle after a deselected state stays off
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mask_r <= 1'b0;
    end else begin
      mask_r <= start & acc_rd & (state_r == PSB_IDLE);
    end
  end

  // self-timed commit of the selected lanes only
  always_ff @(posedge clk_sys_in) begin
    if (acc_wr) begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_we[i]) begin
          mem[cur_addr][i*LANE_W +: LANE_W] <=
            din_r[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  assign bif.in_valid = acc_rd;
  assign bif.in_data = rd_data;
  assign bif.out_ready = ~read_hold_in;
  assign read_ready_out = bif.in_ready;
  assign dq_out = bif.out_data;

  assign dq_oe_out = bif.out_valid & ~out_enable_n_in &
    ~mask_r & ~acc_wr & ~deselect &
    (state_r != PSB_IDLE);

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  AST_CTRL_ADDR_STROBE_N_START:
  assert property (c_start && sel_all |=> state_r == PSB_BURST)
    else $error("controller strobe did not start an access");

  AST_PROC_WINS:
  assert property (~proc_addr_strobe_n_r && ~select_primary_n_r &&
      ~ctrl_addr_strobe_n_r && sel_all |=> state_r == PSB_WAIT_WR)
    else $error("controller strobe won over processor strobe");

  AST_READ_START:
  assert property (start && sel_all && all_lanes_write_n_r &&
      lane_write_qualifier_n_r |-> acc_rd && !acc_wr)
    else $error("read start not recognised");

  AST_ADDR_LOAD:
  assert property (start && sel_all |-> cur_addr == addr_r
      ##1 first_r == $past(addr_r[1:0]))
    else $error("start address not loaded");

  AST_READ_LATENCY:
  assert property (acc_rd && !bif.out_valid |=>
      bif.out_valid && dq_out == $past(rd_data))
    else $error("read data not in output register after one edge");

  AST_FIRST_MASK:
  assert property (start && acc_rd && state_r == PSB_IDLE |=> !dq_oe_out)
    else $error("output driven in first cycle after deselect");

  AST_DESELECT_OFF:
  assert property (deselect |-> !dq_oe_out ##1 !dq_oe_out)
    else $error("output driven after deselect");

  AST_PROC_FIRST_NO_WRITE:
  assert property (p_start && sel_all |-> !acc_wr)
    else $error("write in first processor-strobe cycle");

  AST_TWO_CYCLE_WRITE:
  assert property (p_start && sel_all ##1 !start && !all_lanes_write_n_r
      |-> acc_wr && (&lane_we))
    else $error("second-cycle global write missed");

  AST_GLOBAL_ALL:
  assert property (acc_wr && !all_lanes_write_n_r |-> &lane_we)
    else $error("global write skipped a lane");

  AST_QUALIFIER_NEEDED:
  assert property (all_lanes_write_n_r && lane_write_qualifier_n_r |->
      lane_we == '0)
    else $error("lane written without qualifier");

  AST_LANE_KEEP:
  assert property (acc_wr && all_lanes_write_n_r |->
      lane_we == ~lane_write_select_n_r)
    else $error("lane write pattern wrong");

  AST_WRITE_TRISTATE:
  assert property (acc_wr |-> !dq_oe_out)
    else $error("output driven during write");

  AST_WRITE_COMMIT:
  assert property (acc_wr && lane_we[0] |=>
      mem[$past(cur_addr)][LANE_W-1:0] == $past(din_lane0))
    else $error("write data not committed");

  AST_LINEAR_STEP:
  assert property (cont && !burst_step_n_r && !mode_r |->
      cur_low == 2'($past(cur_low) + PSB_STEP_ONE))
    else $error("linear burst did not count up");

  AST_INTERLEAVE_STEP:
  assert property (cont && !burst_step_n_r && mode_r |->
      (cur_low ^ first_r) == 2'(($past(cur_low) ^ first_r) + PSB_STEP_ONE))
    else $error("interleaved burst order wrong");

  AST_HOLD_ADDR:
  assert property (cont && burst_step_n_r |-> cur_addr == $past(cur_addr))
    else $error("address moved without advance");

  CV_BACK_TO_BACK:
  cover property (start && acc_rd ##1 start && acc_rd);

  CV_PROC_WRITE:
  cover property (p_start && sel_all ##1 acc_wr);

  CV_FULL_BURST:
  cover property (start && acc_rd ##1 (cont && !burst_step_n_r) [*3]);

  CV_BUF_FULL:
  cover property (!read_ready_out);
endmodule

// ---- sim/psb_bus_master.sv ----
`timescale 1ns/1ns
module psb_bus_master import psb_pkg::*; #(
  parameter int AW = 4
) (
  input wire logic clk_sys_in,
  input wire logic dev_oe_in,
  input wire logic [PSB_DATA_W-1:0] dev_dq_in,
  output logic [PSB_DATA_W-1:0] bus_dq_out,
  output logic [AW-1:0] addr_out,
  output logic proc_addr_strobe_n_out,
  output logic ctrl_addr_strobe_n_out,
  output logic burst_step_n_out,
  output logic all_lanes_write_n_out,
  output logic lane_write_qualifier_n_out,
  output logic [PSB_LANES-1:0] lane_write_select_n_out,
  output logic select_primary_n_out,
  output logic select_high_out,
  output logic select_third_n_out,
  output logic out_enable_n_out,
  output logic burst_mode_out
);
  logic [PSB_DATA_W-1:0] wdata_r = '0;
  logic [PSB_DATA_W-1:0] last_r = '0;
  logic drive_r = 1'b0;

  // a released line shows the inverse of its last value
  assign bus_dq_out = dev_oe_in ? dev_dq_in : drive_r ? wdata_r : ~last_r;

  always @(posedge clk_sys_in) begin
    last_r <= bus_dq_out;
  end

  initial begin
    {proc_addr_strobe_n_out, ctrl_addr_strobe_n_out} = 2'h3;
    {burst_step_n_out, all_lanes_write_n_out} = 2'h3;
    lane_write_qualifier_n_out = 1'b1;
    lane_write_select_n_out = 4'hF;
    {select_primary_n_out, select_high_out, select_third_n_out} = 3'h2;
    addr_out = '0;
    out_enable_n_out = 1'b1;
    burst_mode_out = 1'b0;
  end

  // one bus cycle, changed just after the edge and held for a cycle
  task automatic cyc(input logic pas, input logic cas, input logic burst_step_n,
      input logic gw, input logic lane_write_qualifier_n, input logic [PSB_LANES-1:0] bw,
      input logic sel, input logic [AW-1:0] a,
      input logic [PSB_DATA_W-1:0] d, input logic drv);
    @(posedge clk_sys_in);
    proc_addr_strobe_n_out <= pas;
    ctrl_addr_strobe_n_out <= cas;
    burst_step_n_out <= burst_step_n;
    all_lanes_write_n_out <= gw;
    lane_write_qualifier_n_out <= lane_write_qualifier_n;
    lane_write_select_n_out <= bw;
    select_primary_n_out <= ~sel;
    select_high_out <= sel;
    select_third_n_out <= ~sel;
    addr_out <= a;
    wdata_r <= d;
    out_enable_n_out <= drv;
    // data only once the device drivers were already turned off
    drive_r <= drv & out_enable_n_out;
  endtask

  // called only while the device is held in reset
  task automatic set_strap(input logic m);
    burst_mode_out <= m;
  endtask
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top import psb_pkg::*;;
  localparam int AW = 4;
  localparam int LW = PSB_DATA_W / PSB_LANES;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic read_hold_in = 1'b0;
  logic [AW-1:0] addr_in;
  logic [PSB_DATA_W-1:0] dq_in, dq_out;
  logic dq_oe_out, read_ready_out, out_enable_n_in, burst_mode_in;
  logic proc_addr_strobe_n_in, ctrl_addr_strobe_n_in, burst_step_n_in;
  logic all_lanes_write_n_in, lane_write_qualifier_n_in;
  logic [PSB_LANES-1:0] lane_write_select_n_in;
  logic select_primary_n_in, select_high_in, select_third_n_in;
  logic [PSB_DATA_W-1:0] mem_q [16];
  logic exp_oe [int];
  logic exp_rdy [int];
  logic [PSB_DATA_W-1:0] exp_dq [int];
  logic mode;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  psb_sram_core #(.ADDR_W(AW)) i_dut (
    .clk_sys_in, .resetn_in, .addr_in, .dq_in, .dq_out, .dq_oe_out,
    .proc_addr_strobe_n_in, .ctrl_addr_strobe_n_in, .burst_step_n_in,
    .all_lanes_write_n_in, .lane_write_qualifier_n_in,
    .lane_write_select_n_in, .select_primary_n_in, .select_high_in,
    .select_third_n_in, .out_enable_n_in, .burst_mode_in, .read_hold_in,
    .read_ready_out);

  psb_bus_master #(.AW(AW)) i_mst (
    .clk_sys_in, .dev_oe_in(dq_oe_out), .dev_dq_in(dq_out),
    .bus_dq_out(dq_in), .addr_out(addr_in),
    .proc_addr_strobe_n_out(proc_addr_strobe_n_in),
    .ctrl_addr_strobe_n_out(ctrl_addr_strobe_n_in),
    .burst_step_n_out(burst_step_n_in),
    .all_lanes_write_n_out(all_lanes_write_n_in),
    .lane_write_qualifier_n_out(lane_write_qualifier_n_in),
    .lane_write_select_n_out(lane_write_select_n_in),
    .select_primary_n_out(select_primary_n_in),
    .select_high_out(select_high_in),
    .select_third_n_out(select_third_n_in),
    .out_enable_n_out(out_enable_n_in), .burst_mode_out(burst_mode_in));

  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
  end

  always @(negedge clk_sys_in) begin
    if (exp_oe.exists(cyc)) begin
      `CHK(dq_oe_out, exp_oe[cyc])
      if (exp_oe[cyc]) `CHK(dq_out, exp_dq[cyc])
    end
    if (exp_rdy.exists(cyc)) `CHK(read_ready_out, exp_rdy[cyc])
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [PSB_DATA_W-1:0] rnd();
    return PSB_DATA_W'({$urandom(), $urandom()});
  endfunction

  task automatic mem_wr(input int a, input logic [PSB_DATA_W-1:0] d,
      input logic gw, input logic lane_write_qualifier_n, input logic [PSB_LANES-1:0] bw);
    for (int i = 0; i < PSB_LANES; i++) begin
      if (!gw || (!lane_write_qualifier_n && !bw[i])) mem_q[a][i*LW+:LW] = d[i*LW+:LW];
    end
  endtask

  // word of address a expected on the bus "at" cycles from now
  task automatic exp_rd(input int at, input logic oe, input int a);
    exp_oe[cyc + at] = oe;
    exp_dq[cyc + at] = mem_q[a];
  endtask

  task automatic cyc_rd(input logic pas, input logic cas, input logic burst_step_n,
      input int a);
    i_mst.cyc(pas, cas, burst_step_n, 1'b1, 1'b1, 4'hF, 1'b1, AW'(a), '0, 1'b0);
  endtask

  task automatic desel();
    i_mst.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 1'b0, '0, '0, 1'b0);
    exp_oe[cyc + 2] = 1'b0;
  endtask

  task automatic burst(input int a);
    int s;
    int lo;
    cyc_rd(1'b0, 1'b1, 1'b1, a);
    exp_oe[cyc + 3] = 1'b0;
    for (int k = 1; k < 6; k++) begin
      s = (k < 3) ? k : 3;
      lo = mode ? ((a ^ s) & 3) : ((a + s) & 3);
      cyc_rd(1'b1, 1'b1, k > 3, a);
      exp_rd(3, 1'b1, (a & 12) | lo);
    end
    desel();
  endtask

  initial begin
    #3000000;
    n_fail++;
    wrap_up();
  end

  initial begin
    int a;
    int r;
    int i;
    logic [PSB_DATA_W-1:0] d;
    logic [PSB_LANES-1:0] bw;
    logic gw;
    logic lane_write_qualifier_n;
    void'($urandom(32'hd053));
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      @(posedge clk_sys_in);
      resetn_in <= 1'b0;
      i_mst.set_strap(mode);
      repeat (20) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      i_mst.cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 1'b1, '0, '0, 1'b1);
      for (a = 0; a < 16; a++) begin
        d = rnd();
        i_mst.cyc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, 1'b1, AW'(a), d, 1'b1);
        mem_wr(a, d, 1'b0, 1'b1, 4'hF);
      end
      for (i = 0; i < 12; i++) begin
        a = $urandom % 16;
        d = rnd();
        bw = 4'($urandom);
        gw = ($urandom % 4) != 0;
        lane_write_qualifier_n = 1'($urandom);
        // both strobes low, write controls active: only the first may act
        i_mst.cyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 1'b1, AW'(a), ~d, 1'b1);
        i_mst.cyc(1'b1, 1'b1, 1'b1, gw, lane_write_qualifier_n, bw, 1'b1, AW'(a), d, 1'b1);
        mem_wr(a, d, gw, lane_write_qualifier_n, bw);
      end
      desel();
      for (a = 0; a < 16; a++) begin
        r = $urandom % 3;
        cyc_rd(r == 2, r == 1, 1'b1, a);
        exp_rd(3, a != 0, a);
      end
      cyc_rd(1'b1, 1'b1, 1'b1, 0);
      desel();
      for (a = 0; a < 4; a++) begin
        burst(4 * ($urandom % 4) + a);
      end
      // stall only once the stale burst words have drained
      for (a = 5; a < 8; a++) begin
        cyc_rd(1'b1, 1'b0, 1'b1, a);
        if (a == 6) read_hold_in <= 1'b1;
      end
      exp_oe[cyc + 1] = 1'b0;
      exp_oe[cyc + 2] = 1'b1;
      exp_dq[cyc + 2] = mem_q[5];
      exp_rdy[cyc + 2] = 1'b0;
      repeat (3) cyc_rd(1'b1, 1'b1, 1'b1, 7);
      read_hold_in <= 1'b0;
      for (i = 0; i < 8; i++) begin
        @(negedge clk_sys_in);
        if (dq_oe_out === 1'b1 && dq_out !== mem_q[5]) break;
      end
      if (i == 8) begin
        n_fail++;
        wrap_up();
      end
      `CHK(dq_out, mem_q[6])
      desel();
    end
    repeat (4) @(posedge clk_sys_in);
    wrap_up();
  end
endmodule
